// ===== rtl/pol_loader.v
// Power-up option loader: strap capture, shadow store, reload after resets, APB register view
// Behaviour
// - capture all straps when power-on reset releases
// - bus width sampled from req64 each PCI reset
// - system controller loaded from bg3in each sysreset
// - other resets reload last power-on captured values
// - load fields cycles after all resets inactive
// - register image enable, space, base from address
// - register image base placed per selected space
// - config image space and offset from address
// - upper config region internal, rest forwarded
// - five-bit offset selects 128 Mbyte PCI page
// - autoid straps from data, software irq cleared
// - sysfail from data strap in reset unless standard autoid
// - isolation strap from data, restored each reset
// - default target image from address lines 13..2
// - address line 1 sets opposite BAR spaces
// - master enable strapped from address line 14
// - req64 high means 32-bit, low 64-bit
// - no slave transfers until images programmed
`include "pol_map.vh"

module pol_loader (
   input  wire        clock,
   input  wire        rst,
   input  wire        power_on_reset_n,
   input  wire        pci_reset_n,
   input  wire        sysrst_n,
   input  wire        req64_n,
   input  wire        bg3in_n,
   input  wire [31:1] vme_address_lines,
   input  wire [31:27] vme_data_lines,
   input  wire        csr_access_valid,
   input  wire [18:0] csr_access_addr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   output reg         options_loaded,
   output reg         sysfail_out,
   output reg         bus_isolation_mode,
   output reg         master_path_enable,
   output reg         local_bus_width,
   output reg         syscon_enable,
   output reg         vme_to_pci_allow,
   output reg         csr_to_internal,
   output reg         csr_forward_valid,
   output reg         csr_forward_io,
   output reg  [31:0] csr_forward_addr
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam NIN = 41;

   wire [NIN-1:0] raw_in;              // All pins from outside the clock domain
   reg  [NIN-1:0] sync1_r;             // First stage, read by second stage only
   reg  [NIN-1:0] sync2_r;             // Second stage
   reg  [NIN-1:0] sync3_r;             // Third stage
   reg  [NIN-1:0] filt_r;              // Accepted level once stages agree

   assign raw_in = {power_on_reset_n, pci_reset_n, sysrst_n, req64_n, bg3in_n,
                    vme_data_lines, vme_address_lines};

   // Plain three-flop chain for every pin
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_r <= {NIN{1'h0}};
         sync2_r <= {NIN{1'h0}};
         sync3_r <= {NIN{1'h0}};
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // A change counts only once the second and third stage agree
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               filt_r[gi] <= 1'h0;
            end else if (sync2_r[gi] == sync3_r[gi]) begin
               filt_r[gi] <= sync3_r[gi];
            end
         end
      end
   endgenerate

   wire [31:1] al_f     = filt_r[30:0];   // Filtered address straps
   wire [31:27] dl_f    = filt_r[35:31];  // Filtered data straps
   wire        bg3in_f  = filt_r[36];
   wire        req64_f  = filt_r[37];
   wire        sys_n_f  = filt_r[38];
   wire        pci_n_f  = filt_r[39];
   wire        por_n_f  = filt_r[40];
   wire        any_rst  = ~por_n_f | ~pci_n_f | ~sys_n_f;

   // ****************************************************************
   // Shadow store of power-on straps
   // ****************************************************************
   reg         por_n_d_r;               // Previous power-on level, for edge
   reg  [31:1] sh_al_r;                 // Captured address straps
   reg  [31:27] sh_dl_r;                // Captured data straps

   // Only the power-on edge writes the store; other resets leave it alone
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         por_n_d_r <= 1'h0;
         sh_al_r   <= 31'h0000_0000;
         sh_dl_r   <= 5'h00;
      end else begin
         por_n_d_r <= por_n_f;
         if (por_n_f & ~por_n_d_r) begin
            sh_al_r <= al_f;
            sh_dl_r <= dl_f;
         end
      end
   end

   // ****************************************************************
   // Pin-sampled options
   // ****************************************************************
   // Width follows req64 throughout PCI reset; last level before release sticks
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         local_bus_width <= 1'h0;
      end else if (~pci_n_f) begin
         local_bus_width <= ~req64_f;
      end
   end

   // System controller taken from bg3in while the VME reset is held
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         syscon_enable <= 1'h1;
      end else if (~sys_n_f | ~por_n_f) begin
         syscon_enable <= ~bg3in_f;
      end
   end

   // ****************************************************************
   // Load sequencer
   // ****************************************************************
   reg  [2:0] load_cnt_r;               // Cycles since all resets released
   wire       load_pulse = ~any_rst & ~options_loaded & (load_cnt_r == `POL_LOAD_CYCLES - 3'h1);

   // Waiting a few cycles lets bus-side logic settle before fields change
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         load_cnt_r     <= 3'h0;
         options_loaded <= 1'h0;
      end else if (any_rst) begin
         load_cnt_r     <= 3'h0;
         options_loaded <= 1'h0;
      end else if (load_pulse) begin
         options_loaded <= 1'h1;
      end else if (~options_loaded) begin
         load_cnt_r     <= load_cnt_r + 3'h1;
      end
   end

   // Base bits placed by the strapped address space
   function [31:0] place_base;
      input [1:0] spc;
      input [7:0] bits;
      begin
         case (spc)
            `POL_SPC_A16: place_base = {16'h0000, bits[7:4], 12'h000};
            `POL_SPC_A24: place_base = {8'h00, bits, 16'h0000};
            `POL_SPC_A32: place_base = {bits, 24'h00_0000};
            default:      place_base = `POL_ZERO32;
         endcase
      end
   endfunction

   // ****************************************************************
   // Option registers
   // ****************************************************************
   reg        ri_en_r;                  // Register image enable
   reg  [1:0] ri_spc_r;                 // Register image space
   reg [31:0] ri_base_r;                // Register image base
   reg        cs_ios_r;                 // Config image: 1 = I/O
   reg  [4:0] cs_off_r;                 // Config image page offset
   reg        std_autoid_enable;
   reg        daisy_chain_autoid_enable;
   reg        ti_en_r;                  // Target image enable
   reg        ti_ios_r;                 // Target image: 1 = I/O
   reg  [1:0] ti_spc_r;                 // Target image VME space
   reg  [3:0] ti_base_r;                // Target base, 256 MB units
   reg  [3:0] ti_bound_r;               // Target bound, 256 MB units
   reg        bar0_io_r;                // First BAR space bit
   reg        bar1_io_r;                // Second BAR space bit
   reg  [4:0] irq_r;                    // Software irq enable, status, map
   reg  [3:0] slv_prog_r;               // General slave registers written

   wire       wr_en  = psel & penable & pwrite;
   wire       sf_clr = wr_en & (paddr == `POL_OFS_CSR_BIT_CLEAR) & pwdata[`POL_BIT_SYSFAIL_CMD];
   wire       sf_set = wr_en & (paddr == `POL_OFS_CSR_BIT_SET) & pwdata[`POL_BIT_SYSFAIL_CMD];

   // Resets clear all but the isolation and BAR space bits, load applies shadow, otherwise software may rewrite
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ri_en_r <= 1'h0; ri_spc_r <= `POL_SPC_A16; ri_base_r <= `POL_ZERO32;
         cs_ios_r <= 1'h0; cs_off_r <= 5'h00;
         std_autoid_enable <= 1'h0; daisy_chain_autoid_enable <= 1'h0;
         bus_isolation_mode <= 1'h0; master_path_enable <= 1'h0;
         ti_en_r <= 1'h0; ti_ios_r <= 1'h0; ti_spc_r <= `POL_SPC_A16;
         ti_base_r <= 4'h0; ti_bound_r <= 4'h0;
         bar0_io_r <= 1'h1; bar1_io_r <= 1'h0;
         irq_r <= 5'h00; slv_prog_r <= 4'h0;
      end else if (any_rst) begin
         ri_en_r <= 1'h0; ri_spc_r <= `POL_SPC_A16; ri_base_r <= `POL_ZERO32;
         cs_ios_r <= 1'h0; cs_off_r <= 5'h00;
         std_autoid_enable <= 1'h0; daisy_chain_autoid_enable <= 1'h0;
         master_path_enable <= 1'h0;
         ti_en_r <= 1'h0; ti_ios_r <= 1'h0; ti_spc_r <= `POL_SPC_A16;
         ti_base_r <= 4'h0; ti_bound_r <= 4'h0;
         irq_r <= 5'h00; slv_prog_r <= 4'h0;
      end else if (load_pulse) begin
         ri_en_r   <= sh_al_r[31];
         ri_spc_r  <= sh_al_r[30:29];
         ri_base_r <= place_base(sh_al_r[30:29], sh_al_r[28:21]);
         cs_ios_r  <= sh_al_r[20];
         cs_off_r  <= sh_al_r[19:15];
         daisy_chain_autoid_enable <= sh_dl_r[30];
         std_autoid_enable         <= sh_dl_r[29];
         irq_r                     <= 5'h00;
         bus_isolation_mode        <= sh_dl_r[28];
         master_path_enable        <= sh_al_r[14];
         ti_en_r    <= sh_al_r[13];
         ti_ios_r   <= sh_al_r[12];
         ti_spc_r   <= sh_al_r[11:10];
         ti_base_r  <= sh_al_r[9:6];
         ti_bound_r <= sh_al_r[5:2];
         bar0_io_r  <= ~sh_al_r[1];
         bar1_io_r  <= sh_al_r[1];
      end else if (wr_en) begin
         case (paddr)
            `POL_OFS_REG_IMAGE_CONTROL: begin
               ri_en_r  <= pwdata[`POL_BIT_EN];
               ri_spc_r <= pwdata[`POL_BIT_SPC_LO+1:`POL_BIT_SPC_LO];
            end
            `POL_OFS_REG_IMAGE_BASE:    ri_base_r <= pwdata;
            `POL_OFS_CFG_IMAGE_CONTROL: cs_ios_r  <= pwdata[0];
            `POL_OFS_CFG_OFFSET:        cs_off_r  <= pwdata[4:0];
            `POL_OFS_MISC_CONTROL: begin
               std_autoid_enable         <= pwdata[`POL_BIT_AUTOID_STD];
               bus_isolation_mode        <= pwdata[`POL_BIT_ISOLATION];
               daisy_chain_autoid_enable <= pwdata[`POL_BIT_AUTOID_DAISY];
            end
            `POL_OFS_TARGET_CONTROL: begin
               ti_en_r  <= pwdata[`POL_BIT_EN];
               ti_ios_r <= pwdata[0];
               ti_spc_r <= pwdata[`POL_BIT_SPC_LO+1:`POL_BIT_SPC_LO];
            end
            `POL_OFS_TARGET_BASE:    ti_base_r  <= pwdata[31:28];
            `POL_OFS_TARGET_BOUND:   ti_bound_r <= pwdata[31:28];
            `POL_OFS_FIRST_BAR:      bar0_io_r  <= pwdata[0];
            `POL_OFS_SECOND_BAR:     bar1_io_r  <= pwdata[0];
            `POL_OFS_PCI_CMD_STATUS: master_path_enable <= pwdata[`POL_BIT_MASTER_EN];
            `POL_OFS_VME_IRQ:        irq_r <= pwdata[4:0];
            `POL_OFS_SLV_CONTROL:    slv_prog_r[0] <= 1'h1;
            `POL_OFS_SLV_BASE:       slv_prog_r[1] <= 1'h1;
            `POL_OFS_SLV_BOUND:      slv_prog_r[2] <= 1'h1;
            `POL_OFS_SLV_OFFSET:     slv_prog_r[3] <= 1'h1;
            default: ;
         endcase
      end
   end

   // Slave path opens only after all four image registers were written
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         vme_to_pci_allow <= 1'h0;
      end else begin
         vme_to_pci_allow <= (&slv_prog_r) & ~any_rst;
      end
   end

   // ****************************************************************
   // SYSFAIL driver
   // ****************************************************************
   // Asserted while in reset from the strap; standard autoid needs SYSFAIL
   // itself, so its strap takes precedence. A set write beats a clear.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sysfail_out <= 1'h0;
      end else if (any_rst) begin
         if (~por_n_f) begin
            sysfail_out <= dl_f[27] & ~dl_f[29];
         end else begin
            sysfail_out <= sh_dl_r[27] & ~sh_dl_r[29];
         end
      end else if (sf_set) begin
         sysfail_out <= 1'h1;
      end else if (sf_clr) begin
         sysfail_out <= 1'h0;
      end
   end

   // ****************************************************************
   // Config space decode
   // ****************************************************************
   wire csr_upper = (csr_access_addr >= `POL_CSR_REG_REGION);

   // Upper region goes to internal registers, rest to the selected page
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         csr_to_internal   <= 1'h0;
         csr_forward_valid <= 1'h0;
         csr_forward_io    <= 1'h0;
         csr_forward_addr  <= `POL_ZERO32;
      end else begin
         csr_to_internal   <= csr_access_valid & csr_upper;
         csr_forward_valid <= csr_access_valid & ~csr_upper;
         csr_forward_io    <= cs_ios_r;
         csr_forward_addr  <= {cs_off_r, 8'h00, csr_access_addr};
      end
   end

   // ****************************************************************
   // APB read path
   // ****************************************************************
   reg [31:0] rd_mux;                   // Word at the current address
   reg        rd_hit;                   // Address is mapped

   // Read mux; bit clear/set words read back SYSFAIL, slave base/bound/offset words read as zero
   always @* begin
      rd_mux = `POL_ZERO32;
      rd_hit = 1'h1;
      case (paddr)
         `POL_OFS_REG_IMAGE_CONTROL: rd_mux = {ri_en_r, 13'h0000, ri_spc_r, 16'h0000};
         `POL_OFS_REG_IMAGE_BASE:    rd_mux = ri_base_r;
         `POL_OFS_CFG_IMAGE_CONTROL: rd_mux = {31'h0000_0000, cs_ios_r};
         `POL_OFS_CFG_OFFSET:        rd_mux = {27'h000_0000, cs_off_r};
         `POL_OFS_MISC_CONTROL:      rd_mux = {26'h000_0000, sysfail_out, local_bus_width,
                                               daisy_chain_autoid_enable, syscon_enable,
                                               bus_isolation_mode, std_autoid_enable};
         `POL_OFS_TARGET_CONTROL:    rd_mux = {ti_en_r, 13'h0000, ti_spc_r, 15'h0000, ti_ios_r};
         `POL_OFS_TARGET_BASE:       rd_mux = {ti_base_r, 28'h000_0000};
         `POL_OFS_TARGET_BOUND:      rd_mux = {ti_bound_r, 28'h000_0000};
         `POL_OFS_FIRST_BAR:         rd_mux = {31'h0000_0000, bar0_io_r};
         `POL_OFS_SECOND_BAR:        rd_mux = {31'h0000_0000, bar1_io_r};
         `POL_OFS_PCI_CMD_STATUS:    rd_mux = {29'h0000_0000, master_path_enable, 2'h0};
         `POL_OFS_VME_IRQ:           rd_mux = {27'h000_0000, irq_r};
         `POL_OFS_CSR_BIT_CLEAR:     rd_mux = {31'h0000_0000, sysfail_out};
         `POL_OFS_CSR_BIT_SET:       rd_mux = {31'h0000_0000, sysfail_out};
         `POL_OFS_SLV_CONTROL:       rd_mux = {28'h000_0000, slv_prog_r};
         `POL_OFS_SLV_BASE:          rd_mux = `POL_ZERO32;
         `POL_OFS_SLV_BOUND:         rd_mux = `POL_ZERO32;
         `POL_OFS_SLV_OFFSET:        rd_mux = `POL_ZERO32;
         default:                    rd_hit = 1'h0;
      endcase
   end

   // Read data is captured in the setup cycle so it stands in the access
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= `POL_ZERO32;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'h1;
   assign pslverr = psel & penable & ~rd_hit;

endmodule // pol_loader

// ===== rtl/pol_map.vh
// Register map, field positions, reset values and timing counts of the power-up option loader
`ifndef POL_MAP_VH
`define POL_MAP_VH

// ****************************************************************
// Register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define POL_OFS_REG_IMAGE_CONTROL   12'h000
`define POL_OFS_REG_IMAGE_BASE      12'h004
`define POL_OFS_CFG_IMAGE_CONTROL   12'h008
`define POL_OFS_CFG_OFFSET          12'h00C
`define POL_OFS_MISC_CONTROL        12'h010
`define POL_OFS_TARGET_CONTROL      12'h014
`define POL_OFS_TARGET_BASE         12'h018
`define POL_OFS_TARGET_BOUND        12'h01C
`define POL_OFS_FIRST_BAR           12'h020
`define POL_OFS_SECOND_BAR          12'h024
`define POL_OFS_PCI_CMD_STATUS      12'h028
`define POL_OFS_VME_IRQ             12'h02C
`define POL_OFS_CSR_BIT_CLEAR       12'h030
`define POL_OFS_CSR_BIT_SET         12'h034
`define POL_OFS_SLV_CONTROL         12'h040
`define POL_OFS_SLV_BASE            12'h044
`define POL_OFS_SLV_BOUND           12'h048
`define POL_OFS_SLV_OFFSET          12'h04C

// ****************************************************************
// Field positions
// ****************************************************************
`define POL_BIT_EN                  31
`define POL_BIT_SPC_LO              16
`define POL_BIT_AUTOID_STD          0
`define POL_BIT_ISOLATION           1
`define POL_BIT_SYSCON              2
`define POL_BIT_AUTOID_DAISY        3
`define POL_BIT_WIDTH64             4
`define POL_BIT_SYSFAIL             5
`define POL_BIT_MASTER_EN           2
`define POL_BIT_SYSFAIL_CMD         0

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define POL_SPC_A16                 2'h0
`define POL_SPC_A24                 2'h1
`define POL_SPC_A32                 2'h2
`define POL_ZERO32                  32'h0000_0000
`define POL_CSR_REG_REGION          19'h7_F000

// ****************************************************************
// Timing
// ****************************************************************
`define POL_LOAD_CYCLES             3'h4

`endif

// ===== dv/pol_loader_sva.sv
// Port checker for the power-up option loader
module pol_loader_sva (
   input logic         clock,
   input logic         rst,
   input logic         power_on_reset_n,
   input logic         pci_reset_n,
   input logic         sysrst_n,
   input logic         req64_n,
   input logic         bg3in_n,
   input logic [31:27] vme_data_lines,
   input logic         csr_access_valid,
   input logic [18:0]  csr_access_addr,
   input logic         options_loaded,
   input logic         sysfail_out,
   input logic         local_bus_width,
   input logic         syscon_enable,
   input logic         vme_to_pci_allow,
   input logic         csr_to_internal,
   input logic         csr_forward_valid,
   input logic [31:0]  csr_forward_addr
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Eight steady cycles cover the pin filter plus the register stage
   sequence pci_held_s;
      (!pci_reset_n && $stable(req64_n)) [*8];
   endsequence
   sequence sys_held_s;
      (!sysrst_n && $stable(bg3in_n)) [*8];
   endsequence
   csr_int_a:
      assert property (csr_access_valid && csr_access_addr >= 19'h7_F000 |=> csr_to_internal && !csr_forward_valid)
      else $error("upper config region not kept internal");
   csr_fwd_a:
      assert property (csr_access_valid && csr_access_addr < 19'h7_F000 |=> csr_forward_valid && !csr_to_internal)
      else $error("lower config region not forwarded");
   csr_page_a:
      assert property (csr_access_valid |=> csr_forward_addr[26:0] == {8'h00, $past(csr_access_addr)})
      else $error("forwarded config address wrong");
   bus_width_a:
      assert property (pci_held_s |-> local_bus_width == !req64_n)
      else $error("bus width does not follow req64");
   syscon_load_a:
      assert property (sys_held_s |-> syscon_enable == !bg3in_n)
      else $error("system controller does not follow bg3in");
   hold_off_a:
      assert property ((!sysrst_n) [*8] |-> !options_loaded && !vme_to_pci_allow)
      else $error("options or slave path active during reset");
   load_late_a:
      assert property ($rose(options_loaded) |-> $past(power_on_reset_n, 6) && $past(pci_reset_n, 6) && $past(sysrst_n, 6))
      else $error("options loaded too early");
   sysfail_strap_a:
      assert property ((!power_on_reset_n && $stable(vme_data_lines)) [*8] |-> sysfail_out == (vme_data_lines[27] && !vme_data_lines[29]))
      else $error("sysfail strap not honoured");
endmodule // pol_loader_sva

// ===== dv/pol_board.sv
// Board strap model: option levels on the bus lines around reset release
module pol_board (
   input  logic         clock,
   input  logic         in_reset,
   input  logic [31:1]  strap_a,
   input  logic [31:27] strap_d,
   output logic [31:1]  vme_address_lines,
   output logic [31:27] vme_data_lines
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] held_r = 4'h0;   // Cycles since release, saturating
   // Transceivers turn inward a few clocks after release, so a late sample sees traffic
   always @(posedge clock) begin
      if (in_reset) held_r <= 4'h0;
      else if (held_r != 4'hF) held_r <= held_r + 4'h1;
   end
   // Traffic is the inverse pattern, never the last strap value
   assign vme_address_lines = (held_r < 4'h8) ? strap_a : ~strap_a;
   assign vme_data_lines    = (held_r < 4'h8) ? strap_d : ~strap_d;
endmodule // pol_board

// ===== dv/pol_loader_tb_top.sv
// Self-checking bench for the power-up option loader
module pol_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, csr_access_valid = 1'b0;
   logic         power_on_reset_n = 1'b0, pci_reset_n = 1'b0, sysrst_n = 1'b0, req64_n = 1'b1, bg3in_n = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [18:0]  csr_access_addr = 19'h0_0000;
   logic [31:0]  pwdata = 32'h0000_0000, prdata, csr_forward_addr, q;
   logic [31:1]  strap_a = 31'h0, vme_address_lines, ta;
   logic [31:27] strap_d = 5'h00, vme_data_lines, td;
   logic         pready, pslverr, options_loaded, sysfail_out, bus_isolation_mode, master_path_enable, e, in_reset;
   logic         local_bus_width, syscon_enable, vme_to_pci_allow, csr_to_internal, csr_forward_valid, csr_forward_io;
   int           bad_count = 0, n_tests = 0;
   assign in_reset = !(power_on_reset_n && pci_reset_n && sysrst_n);
   always #50 clock = ~clock;
   pol_loader dut (.*);
   pol_board u_board (.*);
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high at an edge; only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q & m, x);
   endtask
   // Holds resets for ten cycles with new pin levels, then waits for the load
   task automatic resets(input logic por, input logic [31:1] a, input logic [31:27] d, input logic r64, input logic bg);
      int n;
      n = 0;
      @(posedge clock);
      {power_on_reset_n, pci_reset_n, sysrst_n, strap_a, strap_d, req64_n, bg3in_n} <= {~por, 2'b00, a, d, r64, bg};
      repeat (10) @(posedge clock);
      {power_on_reset_n, pci_reset_n, sysrst_n} <= 3'b111;
      repeat (2) @(posedge clock);
      while (options_loaded !== 1'b1 && n < 40) begin
         @(posedge clock);
         n++;
      end
      chk(options_loaded, 32'h0000_0001);
   endtask
   // Fields expected from the captured straps ta/td, width w and system controller s
   task automatic check_opts(input logic w, input logic s);
      logic [31:0] b;
      case (ta[30:29])
         2'h0: b = {16'h0000, ta[28:25], 12'h000};
         2'h1: b = {8'h00, ta[28:21], 16'h0000};
         2'h2: b = {ta[28:21], 24'h00_0000};
         default: b = 32'h0000_0000;
      endcase
      rd(12'h000, 32'h8003_0000, {ta[31], 13'h0000, ta[30:29], 16'h0000});
      rd(12'h004, 32'hFFFF_FFFF, b);
      rd(12'h008, 32'h0000_0001, {31'h0, ta[20]});
      rd(12'h00C, 32'h0000_001F, {27'h0, ta[19:15]});
      rd(12'h010, 32'h0000_003F, {26'h0, td[27] & ~td[29], w, td[30], s, td[28], td[29]});
      rd(12'h014, 32'h8003_0001, {ta[13], 13'h0000, ta[11:10], 15'h0000, ta[12]});
      rd(12'h018, 32'hF000_0000, {ta[9:6], 28'h000_0000});
      rd(12'h01C, 32'hF000_0000, {ta[5:2], 28'h000_0000});
      rd(12'h020, 32'h0000_0001, {31'h0, ~ta[1]});
      rd(12'h024, 32'h0000_0001, {31'h0, ta[1]});
      rd(12'h028, 32'h0000_0004, {29'h0, ta[14], 2'h0});
      rd(12'h02C, 32'h0000_001F, 32'h0000_0000);
      chk({master_path_enable, bus_isolation_mode, local_bus_width, syscon_enable}, {ta[14], td[28], w, s});
   endtask
   // All four space codes, both bus widths, sysfail strap with and without standard autoid
   task automatic t_space();
      for (int k = 0; k < 4; k++) begin
         ta = {1'b1, k[1:0], 28'hA5C_3E96 ^ {28{k[0]}}};
         td = {1'b0, k[1], k[0], ~k[0], 1'b1};
         resets(1'b1, ta, td, k[0], ~k[0]);
         check_opts(~k[0], k[0]);
      end
      $display("t_space done");
   endtask
   // Software changes, then other resets with different pins reload the shadow
   task automatic t_reload();
      apb(1'b1, 12'h034, 32'h0000_0001);
      rd(12'h010, 32'h0000_0020, 32'h0000_0020);
      apb(1'b1, 12'h030, 32'h0000_0001);
      rd(12'h010, 32'h0000_0020, 32'h0000_0000);
      apb(1'b1, 12'h010, 32'h0000_0002);
      apb(1'b1, 12'h02C, 32'h0000_001F);
      resets(1'b0, ~ta, ~td, 1'b0, 1'b1);
      check_opts(1'b1, 1'b0);
      $display("t_reload done");
   endtask
   // Back-to-back config accesses on both sides of the internal region
   task automatic t_csr();
      @(posedge clock);
      {csr_access_valid, csr_access_addr} <= {1'b1, 19'h7_F000};
      @(posedge clock);
      csr_access_addr <= 19'h7_EFFF;
      #1 chk({csr_to_internal, csr_forward_valid}, 32'h0000_0002);
      @(posedge clock);
      csr_access_valid <= 1'b0;
      #1 chk({csr_forward_valid, csr_forward_io}, {1'b1, ta[20]});
      chk(csr_forward_addr, {ta[19:15], 8'h00, 19'h7_EFFF});
      $display("t_csr done");
   endtask
   // Slave path shut before any image register write and open once all four are written
   task automatic t_slave();
      chk(vme_to_pci_allow, 32'h0000_0000);
      rd(12'h03C, 32'hFFFF_FFFF, 32'h0000_0000);
      chk(e, 32'h0000_0001);
      for (int i = 0; i < 4; i++) apb(1'b1, 12'(12'h040 + 4 * i), 32'h0000_0001);
      @(posedge clock);
      #1 chk(vme_to_pci_allow, 32'h0000_0001);
      $display("t_slave done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_space();
      t_reload();
      t_csr();
      t_slave();
      end_sim();
   end
   // Watchdog, about thirty times the expected run
   initial begin
      #1_000_000;
      bad_count++;
      end_sim();
   end
endmodule // pol_loader_tb_top
bind pol_loader pol_loader_sva u_sva (.*);
